// [hw/ssa_consts.svh]
// Offsets, field positions, reset values and sizes of the slot-assignment block.
`ifndef SSA_CONSTS_SVH
`define SSA_CONSTS_SVH
`define SSA_ADDR_W 8
`define SSA_OFF_RX_ASSIGN 8'h00
`define SSA_OFF_CTRL_ASSIGN 8'h04
`define SSA_OFF_MODE 8'h08
`define SSA_OFF_CTRL_TX 8'h0C
`define SSA_OFF_CTRL_RX 8'h10
`define SSA_OFF_RX_DATA 8'h14
`define SSA_HI_EN_BIT 15
`define SSA_HI_SLOT_MSB 11
`define SSA_HI_SLOT_LSB 8
`define SSA_LO_EN_BIT 7
`define SSA_LO_SLOT_MSB 3
`define SSA_LO_SLOT_LSB 0
`define SSA_ASSIGN_MASK 16'h8F8F
`define SSA_ASSIGN_RST 16'h0000
`define SSA_FL_MSB 3
`define SSA_FL_LSB 0
`define SSA_FL_RST 4'h0
`define SSA_DATA_RST 16'h0000
`define SSA_SLOT_LAST 4'hF
`define SSA_BIT_LAST 4'hF
`endif

// [hw/ssa_pkg.sv]
// Types shared by the slot-assignment block.
package ssa_pkg;
    typedef logic [3:0] ssa_slot_t;
    typedef logic [15:0] ssa_word_t;
    typedef logic [31:0] ssa_bus_t;
endpackage

// [hw/ssa_slot_assign.sv]
// Slot assignment for receive audio and control channels of a framed serial port.
`timescale 1ns/10ps
`default_nettype none
`include "ssa_consts.svh"

// Contract
// - Left receive data captured only while left receive enable bit 15 is set.
// - Left receive slot is bits 11..8, values 0 to 14; 15 is forbidden.
// - Word from the assigned left slot lands in the left data field.
// - Right receive data captured only while right receive enable bit 7 is set.
// - Right receive slot is bits 3..0, values 0 to 14; 15 is forbidden.
// - Word from the assigned right slot lands in the right data field.
// - Reserved bits of both assignment registers read zero; software writes zero.
// - Control slots act only when frame length field MSB is one.
// - Control channel 0 enable bit 15 gates its transmit and receive.
// - Control channel 0 slot is bits 11..8, shared by both directions.
// - Channel 0 slot sends its transmit field and stores into its receive field.
// - Control channel 1 enable bit 7 gates its transmit and receive.
// - Control channel 1 slot is bits 3..0, shared by both directions.
// - Channel 1 slot sends its transmit field unless enabled channel 0 has the same slot, and stores into its receive field.
module ssa_slot_assign
    import ssa_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [`SSA_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic serial_clk,
    input wire logic frame_sync,
    input wire logic serial_rxd,
    output logic serial_txd,
    output logic serial_txd_oe_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    function automatic logic slot_hit(
        input logic en,
        input ssa_slot_t slot,
        input ssa_slot_t cnt
    );
        // A forbidden slot code never matches, so slot 15 stays idle.
        slot_hit = en && (slot == cnt) && (slot != `SSA_SLOT_LAST);
    endfunction

    function automatic logic agreed(
        input logic s2,
        input logic s3
    );
        agreed = (s2 == s3);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    ssa_word_t rx_assign_r;
    ssa_word_t ctrl_assign_r;
    logic [3:0] frame_len_r;
    ssa_word_t ctrl0_tx_field_r;
    ssa_word_t ctrl1_tx_field_r;
    ssa_word_t ctrl0_rx_field_r;
    ssa_word_t ctrl1_rx_field_r;
    ssa_word_t rx_left_data_field_r;
    ssa_word_t rx_right_data_field_r;
    ssa_bus_t rdata_r;
    ssa_bus_t rdata_nxt;

    logic rx_left_enable;
    ssa_slot_t rx_left_slot;
    logic rx_right_enable;
    ssa_slot_t rx_right_slot;
    logic ctrl_active;
    logic ctrl0_enable;
    ssa_slot_t ctrl0_slot;
    logic ctrl1_enable;
    ssa_slot_t ctrl1_slot;

    assign rx_left_enable = rx_assign_r[`SSA_HI_EN_BIT];
    assign rx_left_slot = rx_assign_r[`SSA_HI_SLOT_MSB:`SSA_HI_SLOT_LSB];
    assign rx_right_enable = rx_assign_r[`SSA_LO_EN_BIT];
    assign rx_right_slot = rx_assign_r[`SSA_LO_SLOT_MSB:`SSA_LO_SLOT_LSB];
    assign ctrl_active = frame_len_r[`SSA_FL_MSB];
    assign ctrl0_enable = ctrl_active && ctrl_assign_r[`SSA_HI_EN_BIT];
    assign ctrl0_slot = ctrl_assign_r[`SSA_HI_SLOT_MSB:`SSA_HI_SLOT_LSB];
    assign ctrl1_enable = ctrl_active && ctrl_assign_r[`SSA_LO_EN_BIT];
    assign ctrl1_slot = ctrl_assign_r[`SSA_LO_SLOT_MSB:`SSA_LO_SLOT_LSB];

    // Reserved bits are masked at the write, so they can never read back as one.
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_assign_r <= `SSA_ASSIGN_RST;
        end else if (reg_wr && reg_addr == `SSA_OFF_RX_ASSIGN) begin
            rx_assign_r <= reg_wdata[15:0] & `SSA_ASSIGN_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_assign_r <= `SSA_ASSIGN_RST;
        end else if (reg_wr && reg_addr == `SSA_OFF_CTRL_ASSIGN) begin
            ctrl_assign_r <= reg_wdata[15:0] & `SSA_ASSIGN_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            frame_len_r <= `SSA_FL_RST;
        end else if (reg_wr && reg_addr == `SSA_OFF_MODE) begin
            frame_len_r <= reg_wdata[`SSA_FL_MSB:`SSA_FL_LSB];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl0_tx_field_r <= `SSA_DATA_RST;
            ctrl1_tx_field_r <= `SSA_DATA_RST;
        end else if (reg_wr && reg_addr == `SSA_OFF_CTRL_TX) begin
            ctrl0_tx_field_r <= reg_wdata[31:16];
            ctrl1_tx_field_r <= reg_wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (!reg_rd) begin
            rdata_nxt = 32'h0000_0000;
        end else if (reg_addr == `SSA_OFF_RX_ASSIGN) begin
            rdata_nxt = {16'h0000, rx_assign_r};
        end else if (reg_addr == `SSA_OFF_CTRL_ASSIGN) begin
            rdata_nxt = {16'h0000, ctrl_assign_r};
        end else if (reg_addr == `SSA_OFF_MODE) begin
            rdata_nxt = {28'h000_0000, frame_len_r};
        end else if (reg_addr == `SSA_OFF_CTRL_TX) begin
            rdata_nxt = {ctrl0_tx_field_r, ctrl1_tx_field_r};
        end else if (reg_addr == `SSA_OFF_CTRL_RX) begin
            rdata_nxt = {ctrl0_rx_field_r, ctrl1_rx_field_r};
        end else if (reg_addr == `SSA_OFF_RX_DATA) begin
            rdata_nxt = {rx_left_data_field_r, rx_right_data_field_r};
        end else begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------

    // Three stages per pin; a level is accepted only once stages two and three agree.
    logic [2:0] sck_sync_r;
    logic [2:0] fsync_sync_r;
    logic [2:0] rxd_sync_r;
    logic sck_r;
    logic fsync_r;
    logic rxd_r;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge clock) begin
        if (srst) begin
            sck_sync_r <= 3'h0;
            fsync_sync_r <= 3'h0;
            rxd_sync_r <= 3'h0;
        end else begin
            sck_sync_r <= {sck_sync_r[1:0], serial_clk};
            fsync_sync_r <= {fsync_sync_r[1:0], frame_sync};
            rxd_sync_r <= {rxd_sync_r[1:0], serial_rxd};
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sck_r <= 1'b0;
            fsync_r <= 1'b0;
            rxd_r <= 1'b0;
        end else begin
            if (agreed(sck_sync_r[1], sck_sync_r[2])) begin
                sck_r <= sck_sync_r[2];
            end
            if (agreed(fsync_sync_r[1], fsync_sync_r[2])) begin
                fsync_r <= fsync_sync_r[2];
            end
            if (agreed(rxd_sync_r[1], rxd_sync_r[2])) begin
                rxd_r <= rxd_sync_r[2];
            end
        end
    end

    assign sck_rise = !sck_r && agreed(sck_sync_r[1], sck_sync_r[2]) && sck_sync_r[2];
    assign sck_fall = sck_r && agreed(sck_sync_r[1], sck_sync_r[2]) && !sck_sync_r[2];

    // ------------------------------------------------------------
    // Slot counting and receive
    // ------------------------------------------------------------

    ssa_slot_t bit_cnt_r;
    ssa_slot_t slot_cnt_r;
    logic [14:0] shift_r;
    logic word_done;
    ssa_word_t word_in;
    ssa_slot_t word_slot;

    // Frame sync seen at a rising edge marks bit 0 of slot 0.
    assign word_done = sck_rise && !fsync_r && (bit_cnt_r == `SSA_BIT_LAST);
    assign word_in = {shift_r, rxd_r};
    assign word_slot = slot_cnt_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            bit_cnt_r <= 4'h0;
            slot_cnt_r <= `SSA_SLOT_LAST;
            shift_r <= 15'h0000;
        end else if (sck_rise) begin
            shift_r <= word_in[14:0];
            if (fsync_r) begin
                bit_cnt_r <= 4'h1;
                slot_cnt_r <= 4'h0;
            end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                // Slot count stops at 15 so a long frame never wraps onto slot 0.
                if (word_done && slot_cnt_r != `SSA_SLOT_LAST) begin
                    slot_cnt_r <= slot_cnt_r + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_left_data_field_r <= `SSA_DATA_RST;
        end else if (word_done && slot_hit(rx_left_enable, rx_left_slot, word_slot)) begin
            rx_left_data_field_r <= word_in;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_right_data_field_r <= `SSA_DATA_RST;
        end else if (word_done && slot_hit(rx_right_enable, rx_right_slot, word_slot)) begin
            rx_right_data_field_r <= word_in;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl0_rx_field_r <= `SSA_DATA_RST;
        end else if (word_done && slot_hit(ctrl0_enable, ctrl0_slot, word_slot)) begin
            ctrl0_rx_field_r <= word_in;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl1_rx_field_r <= `SSA_DATA_RST;
        end else if (word_done && slot_hit(ctrl1_enable, ctrl1_slot, word_slot)) begin
            ctrl1_rx_field_r <= word_in;
        end
    end

    // ------------------------------------------------------------
    // Control transmit
    // ------------------------------------------------------------

    // Bits go out msb first on the falling edge before they are sampled.
    // The slot position of the very first bit of a frame is unknown until sync
    // arrives, so transmission of slot 0 begins with its second bit.
    logic txd_r;
    logic txd_oe_n_r;
    logic tx0_hit;
    logic tx1_hit;
    ssa_slot_t tx_bit_idx;

    assign tx0_hit = slot_hit(ctrl0_enable, ctrl0_slot, slot_cnt_r);
    assign tx1_hit = slot_hit(ctrl1_enable, ctrl1_slot, slot_cnt_r);
    assign tx_bit_idx = `SSA_BIT_LAST - bit_cnt_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            txd_r <= 1'b0;
            txd_oe_n_r <= 1'b1;
        end else if (sck_fall) begin
            if (tx0_hit) begin
                txd_r <= ctrl0_tx_field_r[tx_bit_idx];
                txd_oe_n_r <= 1'b0;
            end else if (tx1_hit) begin
                txd_r <= ctrl1_tx_field_r[tx_bit_idx];
                txd_oe_n_r <= 1'b0;
            end else begin
                txd_r <= 1'b0;
                txd_oe_n_r <= 1'b1;
            end
        end
    end

    assign serial_txd = txd_r;
    assign serial_txd_oe_n = txd_oe_n_r;

endmodule
`default_nettype wire

// [verification/ssa_slot_assign_asserts.sv]
// Assertion checker for the slot-assignment block.
`timescale 1ns/10ps
`default_nettype none
`include "ssa_consts.svh"
module ssa_slot_assign_asserts (
    input wire logic clock,
    input wire logic srst,
    input wire logic [`SSA_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic serial_clk,
    input wire logic frame_sync,
    input wire logic serial_rxd,
    input wire logic serial_txd,
    input wire logic serial_txd_oe_n
);
    logic mode_r;
    logic ctl_en_r;
    logic seen_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Shadows of the gating state, so the pin can be tied back to software.
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_r <= 1'b0;
            ctl_en_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `SSA_OFF_MODE) begin
                mode_r <= reg_wdata[`SSA_FL_MSB];
            end
            if (reg_wr && reg_addr == `SSA_OFF_CTRL_ASSIGN) begin
                ctl_en_r <= reg_wdata[`SSA_HI_EN_BIT] | reg_wdata[`SSA_LO_EN_BIT];
            end
            if (frame_sync) begin
                seen_r <= 1'b1;
            end
        end
    end
    property p_rx_rsvd;
        reg_rd && reg_addr == `SSA_OFF_RX_ASSIGN
        |=> (reg_rdata & ~{16'h0000, `SSA_ASSIGN_MASK}) == 32'h0000_0000;
    endproperty
    a_rx_rsvd: assert property (p_rx_rsvd) else $error("rx assign reserved bits set");
    property p_ct_rsvd;
        reg_rd && reg_addr == `SSA_OFF_CTRL_ASSIGN
        |=> (reg_rdata & ~{16'h0000, `SSA_ASSIGN_MASK}) == 32'h0000_0000;
    endproperty
    a_ct_rsvd: assert property (p_ct_rsvd) else $error("ctrl assign reserved bits set");
    property p_rx_wr;
        reg_wr && reg_addr == `SSA_OFF_RX_ASSIGN ##1 reg_rd && reg_addr == `SSA_OFF_RX_ASSIGN
        |=> reg_rdata[15:0] == ($past(reg_wdata[15:0], 2) & `SSA_ASSIGN_MASK);
    endproperty
    a_rx_wr: assert property (p_rx_wr) else $error("rx assign readback wrong");
    property p_ct_wr;
        reg_wr && reg_addr == `SSA_OFF_CTRL_ASSIGN ##1 reg_rd && reg_addr == `SSA_OFF_CTRL_ASSIGN
        |=> reg_rdata[15:0] == ($past(reg_wdata[15:0], 2) & `SSA_ASSIGN_MASK);
    endproperty
    a_ct_wr: assert property (p_ct_wr) else $error("ctrl assign readback wrong");
    property p_mode_rd;
        reg_wr && reg_addr == `SSA_OFF_MODE ##1 reg_rd && reg_addr == `SSA_OFF_MODE
        |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2);
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("frame length readback wrong");
    property p_ctl_gate;
        !serial_txd_oe_n |-> mode_r || $past(mode_r);
    endproperty
    a_ctl_gate: assert property (p_ctl_gate) else $error("driven with control off");
    property p_ctl_en;
        !serial_txd_oe_n |-> ctl_en_r || $past(ctl_en_r);
    endproperty
    a_ctl_en: assert property (p_ctl_en) else $error("driven with channels off");
    property p_sync_first;
        !serial_txd_oe_n |-> seen_r;
    endproperty
    a_sync_first: assert property (p_sync_first) else $error("driven before any frame");
endmodule
bind ssa_slot_assign ssa_slot_assign_asserts u_chk (.clock(clock), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_clk(serial_clk), .frame_sync(frame_sync),
    .serial_rxd(serial_rxd), .serial_txd(serial_txd), .serial_txd_oe_n(serial_txd_oe_n));
`default_nettype wire

// [verification/ssa_codec_model.sv]
// Behavioural codec that owns the serial clock and frame sync.
`timescale 1ns/10ps
`default_nettype none
module ssa_codec_model
    import ssa_pkg::*;
(
    input wire logic clock,
    input wire logic serial_txd,
    input wire logic serial_txd_oe_n,
    output logic serial_clk,
    output logic frame_sync,
    output logic serial_rxd
);
    ssa_word_t tx_word [4];
    logic tx_drv [4];
    initial begin
        serial_clk = 1'b0;
        frame_sync = 1'b0;
        serial_rxd = 1'b0;
    end
    // The clock stands low between frames; the data line flips once released.
    task automatic send_frame(input logic [3:0][15:0] w, input int hp);
        @(posedge clock);
        #3;
        for (int s = 0; s < 4; s++) begin
            tx_drv[s] = 1'b1;
            for (int b = 15; b >= 0; b--) begin
                serial_rxd = w[3-s][b];
                frame_sync = (s == 0 && b == 15);
                #(hp * 20);
                serial_clk = 1'b1;
                tx_word[s][b] = serial_txd;
                tx_drv[s] = tx_drv[s] & ~serial_txd_oe_n;
                #(hp * 20);
                serial_clk = 1'b0;
            end
        end
        frame_sync = 1'b0;
        serial_rxd = ~serial_rxd;
    endtask
endmodule
`default_nettype wire

// [verification/ssa_slot_assign_tb.sv]
// Self-checking bench for the slot-assignment block.
`timescale 1ns/10ps
`default_nettype none
`include "ssa_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module ssa_slot_assign_tb
    import ssa_pkg::*;
;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [`SSA_ADDR_W-1:0] reg_addr = '0;
    ssa_bus_t reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    ssa_bus_t reg_rdata;
    logic serial_clk, frame_sync, serial_rxd, serial_txd, serial_txd_oe_n;
    int n_errors = 0;
    int samples_checked = 0;
    ssa_slot_assign u_dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_clk(serial_clk), .frame_sync(frame_sync), .serial_rxd(serial_rxd),
        .serial_txd(serial_txd), .serial_txd_oe_n(serial_txd_oe_n));
    ssa_codec_model u_codec (.clock(clock), .serial_txd(serial_txd),
        .serial_txd_oe_n(serial_txd_oe_n), .serial_clk(serial_clk),
        .frame_sync(frame_sync), .serial_rxd(serial_rxd));
    initial begin
        forever #10 clock = ~clock;
    end
    // Both tasks are called just after a rising edge and return just after one.
    // The write strobe stays up into the next call, so writes and a following
    // read run back to back; a read must therefore close every run of writes.
    task automatic wr(input logic [`SSA_ADDR_W-1:0] a, input ssa_bus_t d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
    endtask
    task automatic rc(input logic [`SSA_ADDR_W-1:0] a, input ssa_bus_t e);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
        @(posedge clock);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) rc(`SSA_ADDR_W'(i * 4), 32'h0000_0000);
        $display("reset test done");
        wr(`SSA_OFF_RX_ASSIGN, 32'hFFFF_FFFF);
        rc(`SSA_OFF_RX_ASSIGN, 32'h0000_8F8F);
        wr(`SSA_OFF_CTRL_ASSIGN, 32'hFFFF_FFFF);
        rc(`SSA_OFF_CTRL_ASSIGN, 32'h0000_8F8F);
        $display("reserved test done");
        wr(`SSA_OFF_RX_ASSIGN, 32'h0000_8283);
        wr(`SSA_OFF_CTRL_ASSIGN, 32'h0000_8182);
        wr(`SSA_OFF_MODE, 32'h0000_0007);
        wr(`SSA_OFF_CTRL_TX, 32'hA5C3_3C5A);
        rc(`SSA_OFF_CTRL_TX, 32'hA5C3_3C5A);
        u_codec.send_frame({16'h1111, 16'h2222, 16'h3333, 16'h4444}, 12);
        repeat (10) @(posedge clock);
        rc(`SSA_OFF_RX_DATA, 32'h3333_4444);
        rc(`SSA_OFF_CTRL_RX, 32'h0000_0000);
        `CHK(u_codec.tx_drv[1] | u_codec.tx_drv[2], 1'b0)
        $display("control off test done");
        wr(`SSA_OFF_MODE, 32'h0000_0008);
        rc(`SSA_OFF_MODE, 32'h0000_0008);
        u_codec.send_frame({16'h5555, 16'h6666, 16'h7777, 16'h8888}, 12);
        repeat (10) @(posedge clock);
        rc(`SSA_OFF_CTRL_RX, 32'h6666_7777);
        rc(`SSA_OFF_RX_DATA, 32'h7777_8888);
        `CHK(u_codec.tx_word[1], 16'hA5C3)
        `CHK(u_codec.tx_word[2], 16'h3C5A)
        `CHK(u_codec.tx_drv[1] & u_codec.tx_drv[2], 1'b1)
        $display("control on test done");
        wr(`SSA_OFF_RX_ASSIGN, 32'h0000_0180);
        wr(`SSA_OFF_CTRL_ASSIGN, 32'h0000_0083);
        wr(`SSA_OFF_MODE, 32'h0000_000F);
        rc(`SSA_OFF_MODE, 32'h0000_000F);
        u_codec.send_frame({16'h9999, 16'hAAAA, 16'hBBBB, 16'hCCCC}, 20);
        repeat (10) @(posedge clock);
        rc(`SSA_OFF_RX_DATA, 32'h7777_9999);
        rc(`SSA_OFF_CTRL_RX, 32'h6666_CCCC);
        `CHK(u_codec.tx_word[3], 16'h3C5A)
        `CHK({u_codec.tx_drv[1], u_codec.tx_drv[3]}, 2'b01)
        $display("disable test done");
        test_done;
    end
endmodule
`default_nettype wire
